// File: rtl/tssc_consts.vh
// Overview of operation
// [RULE1] A global write changes running flag n+4 only where mask bit n of the byte is one.
// [RULE2] Global bits 7..4 read timers 3..0 running, and a masked write starts or stops them.
// [RULE3] With halt_on_receive set, a timer stops once the first 4 received bits have arrived.
// [RULE4] halt_on_receive has no effect while auto_start_select picks oscillator trimming.
// [RULE5] auto_start_select 00b gives no auto start; 01b starts the timer when transmission ends.
// [RULE6] auto_start_select 1xb toggles running on oscillator rising edges, 11b with underflow.
// [RULE7] With reload_on_zero set the counter reloads at zero and counts on, else it stops there.
// [RULE8] Each underflow sets that timer's interrupt request flag.
// [RULE9] Timer 0 source 00b counts 13.56 MHz ticks and 01b counts 211.875 kHz ticks.
// [RULE10] Timer 0 source 10b counts timer 2 underflows and 11b counts timer 1 underflows.
// [RULE11] halt_on_receive 7, auto_start_select 5:4, reload_on_zero 3, source 1:0; 6, 2 reserved.
// [RULE12] A start loads the counter from the reload bytes; a new reload acts at the next start.
// [RULE13] Timer 1 source 10b counts timer 0 underflows and 11b counts timer 2 underflows.
// [RULE14] A running counter drops by one per tick of its source; a cascade tick is one underflow.
`ifndef TSSC_CONSTS_VH
`define TSSC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define TSSC_ADDR_GLOBAL 8'h0E
`define TSSC_ADDR_TIMER_BASE 8'h0F
`define TSSC_TIMER_STRIDE 8'h05
`define TSSC_ADDR_IRQ_FLAGS 8'h23

// Field index inside one timer's group of five registers.
`define TSSC_FLD_CTRL 3'd0
`define TSSC_FLD_RELOAD_HI 3'd1
`define TSSC_FLD_RELOAD_LO 3'd2
`define TSSC_FLD_COUNT_HI 3'd3
`define TSSC_FLD_COUNT_LO 3'd4

// ----------------------------------------------------------------------------
// Control byte fields and reset values
// ----------------------------------------------------------------------------
`define TSSC_CTRL_HALT_RX 7
`define TSSC_CTRL_AUTO_HI 5
`define TSSC_CTRL_AUTO_LO 4
`define TSSC_CTRL_RELOAD_ZERO 3
`define TSSC_CTRL_SRC_HI 1
`define TSSC_CTRL_SRC_LO 0
`define TSSC_CTRL_WMASK 8'hBB
`define TSSC_CTRL_RESET 8'h00
`define TSSC_RELOAD_RESET 16'h0000
`define TSSC_GLOBAL_RUN_LO 4

`define TSSC_AUTO_NONE 2'b00
`define TSSC_AUTO_TX_END 2'b01
`define TSSC_AUTO_LFO_NO_UF 2'b10
`define TSSC_AUTO_LFO_UF 2'b11

`define TSSC_SRC_FAST 2'b00
`define TSSC_SRC_SLOW 2'b01
`define TSSC_SRC_CASC_A 2'b10
`define TSSC_SRC_CASC_B 2'b11

`endif

// File: rtl/tssc_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "tssc_consts.vh"

module tssc_timer (
    input wire mclk_in,          // System clock.
    input wire sys_rst_in,       // Synchronous reset, active high.
    input wire [7:0] ctrl_in,    // Control byte of this timer.
    input wire [15:0] reload_in, // Reload value.
    input wire tick_in,          // Selected tick, one cycle per count.
    input wire sw_start_in,      // Software start pulse.
    input wire sw_stop_in,       // Software stop pulse.
    input wire tx_end_in,        // End of transmission pulse.
    input wire rx_first4_in,     // First 4 received bits pulse.
    input wire lfo_rise_in,      // Oscillator rising edge pulse.
    output reg running_out,      // Timer is running.
    output reg [15:0] count_out, // Counter value.
    output reg underflow_out     // One-cycle underflow pulse.
);

    wire [1:0] auto_sel;
    wire lfo_mode;
    reg start_ev;
    reg stop_ev;

    assign auto_sel = ctrl_in[`TSSC_CTRL_AUTO_HI:`TSSC_CTRL_AUTO_LO];
    assign lfo_mode = auto_sel[1];

    // ------------------------------------------------------------------------
    // Start and stop events
    // ------------------------------------------------------------------------
    always @* begin
        start_ev = sw_start_in;
        stop_ev = sw_stop_in;
        if (auto_sel == `TSSC_AUTO_TX_END && tx_end_in) begin
            start_ev = 1'b1; // RULE5
        end
        if (lfo_mode && lfo_rise_in) begin
            // Each rising edge toggles, so one oscillator period is measured.
            if (running_out) begin
                stop_ev = 1'b1; // RULE6
            end else begin
                start_ev = 1'b1; // RULE6
            end
        end
        if (ctrl_in[`TSSC_CTRL_HALT_RX] && !lfo_mode && rx_first4_in) begin
            stop_ev = 1'b1; // RULE3 RULE4
        end
    end

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            running_out <= 1'b0;
            count_out <= `TSSC_RELOAD_RESET;
            underflow_out <= 1'b0;
        end else begin
            underflow_out <= 1'b0;
            if (stop_ev) begin
                running_out <= 1'b0; // RULE1
            end else if (start_ev) begin
                running_out <= 1'b1;
                count_out <= reload_in; // RULE12
            end else if (running_out && tick_in) begin
                if (count_out != 16'h0000) begin
                    count_out <= count_out - 16'h0001; // RULE14
                end else if (auto_sel == `TSSC_AUTO_LFO_NO_UF) begin
                    // Trimming without underflow holds at zero until the next edge.
                    count_out <= 16'h0000; // RULE6
                end else begin
                    underflow_out <= 1'b1; // RULE8
                    if (ctrl_in[`TSSC_CTRL_RELOAD_ZERO]) begin
                        count_out <= reload_in; // RULE7
                    end else begin
                        running_out <= 1'b0; // RULE7
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: rtl/tssc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "tssc_consts.vh"

module tssc_top (
    input wire mclk_in,                       // System clock, 100 MHz.
    input wire sys_rst_in,                    // Synchronous reset, active high.
    input wire [7:0] addr_in,                 // Register address.
    input wire [7:0] wr_data_in,              // Write data.
    input wire wr_en_in,                      // Write strobe.
    input wire rd_en_in,                      // Read strobe.
    output reg [7:0] rd_data_out,             // Read data, cycle after the strobe.
    input wire tick_fast_in,                  // 13.56 MHz tick pulse.
    input wire tick_slow_in,                  // 211.875 kHz tick pulse.
    input wire tx_end_in,                     // End of transmission pulse.
    input wire rx_first4_in,                  // First 4 received bits pulse.
    input wire low_freq_oscillator_in,        // Oscillator level for trimming.
    output wire [3:0] timer_active_out,       // Running state of timers 3..0.
    output reg [3:0] underflow_irq_flag_out   // Sticky underflow flags.
);

    reg [31:0] ctrl_q;
    reg [63:0] reload_q;
    reg lfo_q;
    reg lfo_rise_q;
    reg [3:0] sw_start;
    reg [3:0] sw_stop;
    reg [7:0] rd_data_d;
    reg [3:0] tick;
    wire [63:0] count;
    wire [3:0] underflow;
    wire [5:0] wr_dec;
    wire [5:0] rd_dec;

    // ------------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------------
    // Returns {hit, timer index, field} for the per-timer register groups.
    function [5:0] tssc_decode;
        input [7:0] addr;
        integer i;
        reg [7:0] base;
        reg [7:0] offs;
        begin
            tssc_decode = 6'h00;
            offs = 8'h00;
            for (i = 0; i < 4; i = i + 1) begin
                base = `TSSC_ADDR_TIMER_BASE + `TSSC_TIMER_STRIDE * i[7:0];
                if (addr >= base && addr < base + `TSSC_TIMER_STRIDE) begin
                    offs = addr - base;
                    tssc_decode = {1'b1, i[1:0], offs[2:0]};
                end
            end
        end
    endfunction

    // Cascade source of each timer; timers 2 and 3 follow a fixed choice.
    function [1:0] tssc_casc;
        input [1:0] timer;
        input sel_b;
        begin
            if (timer == 2'd0) begin
                tssc_casc = sel_b ? 2'd1 : 2'd2; // RULE10
            end else if (timer == 2'd1) begin
                tssc_casc = sel_b ? 2'd2 : 2'd0; // RULE13
            end else if (timer == 2'd2) begin
                tssc_casc = sel_b ? 2'd1 : 2'd0;
            end else begin
                tssc_casc = sel_b ? 2'd2 : 2'd0;
            end
        end
    endfunction

    assign wr_dec = tssc_decode(addr_in);
    assign rd_dec = wr_dec;

    // ------------------------------------------------------------------------
    // Software start and stop through the write mask
    // ------------------------------------------------------------------------
    always @* begin
        sw_start = 4'h0;
        sw_stop = 4'h0;
        if (wr_en_in && addr_in == `TSSC_ADDR_GLOBAL) begin
            sw_start = wr_data_in[3:0] & wr_data_in[7:4]; // RULE1 RULE2
            sw_stop = wr_data_in[3:0] & ~wr_data_in[7:4]; // RULE1 RULE2
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ctrl_q <= {4{`TSSC_CTRL_RESET}};
            reload_q <= {4{`TSSC_RELOAD_RESET}};
        end else if (wr_en_in && wr_dec[5]) begin
            if (wr_dec[2:0] == `TSSC_FLD_CTRL) begin
                ctrl_q[8*wr_dec[4:3] +: 8] <= wr_data_in & `TSSC_CTRL_WMASK; // RULE11
            end else if (wr_dec[2:0] == `TSSC_FLD_RELOAD_HI) begin
                reload_q[16*wr_dec[4:3] + 8 +: 8] <= wr_data_in;
            end else if (wr_dec[2:0] == `TSSC_FLD_RELOAD_LO) begin
                reload_q[16*wr_dec[4:3] +: 8] <= wr_data_in;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Oscillator edge detect
    // ------------------------------------------------------------------------
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            lfo_q <= 1'b0;
            lfo_rise_q <= 1'b0;
        end else begin
            lfo_q <= low_freq_oscillator_in;
            lfo_rise_q <= low_freq_oscillator_in & ~lfo_q; // RULE6
        end
    end

    // ------------------------------------------------------------------------
    // Tick selection and timer instances
    // ------------------------------------------------------------------------
    // Cascaded ticks come from registered underflow pulses, so a chain adds
    // one cycle of latency per stage; this keeps the loops free of
    // combinational paths between timers.
    always @* begin : tick_sel
        integer n;
        reg [1:0] src;
        src = 2'b00;
        tick = 4'h0;
        for (n = 0; n < 4; n = n + 1) begin
            src = ctrl_q[8*n + `TSSC_CTRL_SRC_LO +: 2];
            if (src == `TSSC_SRC_FAST) begin
                tick[n] = tick_fast_in; // RULE9
            end else if (src == `TSSC_SRC_SLOW) begin
                tick[n] = tick_slow_in; // RULE9
            end else begin
                tick[n] = underflow[tssc_casc(n[1:0], src[0])]; // RULE10 RULE13 RULE14
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_timer
            tssc_timer u_timer (
                .mclk_in(mclk_in),
                .sys_rst_in(sys_rst_in),
                .ctrl_in(ctrl_q[8*g +: 8]),
                .reload_in(reload_q[16*g +: 16]),
                .tick_in(tick[g]),
                .sw_start_in(sw_start[g]),
                .sw_stop_in(sw_stop[g]),
                .tx_end_in(tx_end_in),
                .rx_first4_in(rx_first4_in),
                .lfo_rise_in(lfo_rise_q),
                .running_out(timer_active_out[g]),
                .count_out(count[16*g +: 16]),
                .underflow_out(underflow[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Underflow flags
    // ------------------------------------------------------------------------
    // Writing ones clears; an underflow in the same cycle wins over the clear.
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            underflow_irq_flag_out <= 4'h0;
        end else if (wr_en_in && addr_in == `TSSC_ADDR_IRQ_FLAGS) begin
            underflow_irq_flag_out <= (underflow_irq_flag_out & ~wr_data_in[3:0]) | underflow;
        end else begin
            underflow_irq_flag_out <= underflow_irq_flag_out | underflow; // RULE8
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    always @* begin
        rd_data_d = 8'h00;
        if (addr_in == `TSSC_ADDR_GLOBAL) begin
            // Mask bits are write-only and read as zero.
            rd_data_d = {timer_active_out, 4'h0}; // RULE2
        end else if (addr_in == `TSSC_ADDR_IRQ_FLAGS) begin
            rd_data_d = {4'h0, underflow_irq_flag_out};
        end else if (rd_dec[5]) begin
            if (rd_dec[2:0] == `TSSC_FLD_CTRL) begin
                rd_data_d = ctrl_q[8*rd_dec[4:3] +: 8];
            end else if (rd_dec[2:0] == `TSSC_FLD_RELOAD_HI) begin
                rd_data_d = reload_q[16*rd_dec[4:3] + 8 +: 8];
            end else if (rd_dec[2:0] == `TSSC_FLD_RELOAD_LO) begin
                rd_data_d = reload_q[16*rd_dec[4:3] +: 8];
            end else if (rd_dec[2:0] == `TSSC_FLD_COUNT_HI) begin
                rd_data_d = count[16*rd_dec[4:3] + 8 +: 8];
            end else if (rd_dec[2:0] == `TSSC_FLD_COUNT_LO) begin
                rd_data_d = count[16*rd_dec[4:3] +: 8];
            end
        end
    end

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            rd_data_out <= rd_data_d;
        end else begin
            rd_data_out <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// File: testbench/tssc_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tssc_checker (
    input wire logic mclk_in, // Clock.
    input wire logic sys_rst_in, // Reset.
    input wire logic [7:0] addr_in, // Address.
    input wire logic [7:0] wr_data_in, // Write data.
    input wire logic wr_en_in, // Write strobe.
    input wire logic rd_en_in, // Read strobe.
    input wire logic [7:0] rd_data_out, // Read data.
    input wire logic tick_fast_in, // Fast tick.
    input wire logic tick_slow_in, // Slow tick.
    input wire logic tx_end_in, // Transmit end.
    input wire logic rx_first4_in, // Receive start.
    input wire logic low_freq_oscillator_in, // Oscillator.
    input wire logic [3:0] timer_active_out, // Running flags.
    input wire logic [3:0] underflow_irq_flag_out // Flags.
);
    logic [7:0] ctrl0_q;
    logic wr_glb;
    // ------------------------------------------------------------------
    // Shadow of the timer 0 control byte, since its fields steer events.
    // ------------------------------------------------------------------
    assign wr_glb = wr_en_in && addr_in == 8'h0E;
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ctrl0_q <= 8'h00;
        end else if (wr_en_in && addr_in == 8'h0F) begin
            ctrl0_q <= wr_data_in & 8'hBB;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_mask_hold: assert property (wr_glb && !wr_data_in[3] && !timer_active_out[3]
        && !tx_end_in |=> !timer_active_out[3]) else $error("masked flag changed");
    a_start_write: assert property (wr_glb && wr_data_in[4] && wr_data_in[0]
        && !rx_first4_in |=> timer_active_out[0]) else $error("start write ignored");
    a_read_running: assert property (rd_en_in && addr_in == 8'h0E
        |=> rd_data_out == {$past(timer_active_out), 4'h0}) else $error("running read wrong");
    a_ctrl_read: assert property (rd_en_in && addr_in == 8'h0F
        |=> rd_data_out == ctrl0_q) else $error("control read wrong");
    a_halt_rx: assert property (rx_first4_in && ctrl0_q[7] && !ctrl0_q[5]
        |=> !timer_active_out[0]) else $error("no stop on receive");
    a_tx_start: assert property (tx_end_in && ctrl0_q[5:4] == 2'b01 && !rx_first4_in
        && !wr_glb |=> timer_active_out[0]) else $error("no start on transmit end");
    a_no_auto: assert property (tx_end_in && ctrl0_q[5:4] == 2'b00 && !wr_glb
        && !timer_active_out[0] |=> !timer_active_out[0]) else $error("unwanted start");
    a_irq_cause: assert property ($rose(underflow_irq_flag_out[0])
        |-> $past(timer_active_out[0], 2)) else $error("flag without running timer");
    c_tx: cover property (tx_end_in && ctrl0_q[5:4] == 2'b01);
    c_rx: cover property (rx_first4_in && ctrl0_q[7]);
    c_irq: cover property ($rose(underflow_irq_flag_out[0]));
endmodule
bind tssc_top tssc_checker tssc_checker_inst (.mclk_in, .sys_rst_in, .addr_in, .wr_data_in,
    .wr_en_in, .rd_en_in, .rd_data_out, .tick_fast_in, .tick_slow_in, .tx_end_in,
    .rx_first4_in, .low_freq_oscillator_in, .timer_active_out, .underflow_irq_flag_out);
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic tick_fast_in = 1'b0;
    logic tick_slow_in = 1'b0;
    logic tx_end_in = 1'b0;
    logic rx_first4_in = 1'b0;
    logic low_freq_oscillator_in = 1'b0;
    wire [7:0] rd_data_out;
    wire [3:0] timer_active_out;
    wire [3:0] underflow_irq_flag_out;
    logic low_freq_oscillator = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q [$];
    string name_q [$];
    int mismatches = 0;
    int checks = 0;
    int k;
    logic [7:0] run, rv, d, m, base;
    logic [7:0] ctl [3] = '{8'h90, 8'h10, 8'h00};
    logic [7:0] e1 [3] = '{8'h10, 8'h10, 8'h00};
    logic [7:0] e2 [3] = '{8'h00, 8'h10, 8'h00};

    initial forever #5 mclk_in = ~mclk_in;

    tssc_top tssc_top_inst (.mclk_in, .sys_rst_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
        .rd_data_out, .tick_fast_in, .tick_slow_in, .tx_end_in, .rx_first4_in,
        .low_freq_oscillator_in, .timer_active_out, .underflow_irq_flag_out);

    // ------------------------------------------------------------------
    // Drivers: every bus call owns one cycle, so no signal is set twice a step.
    // ------------------------------------------------------------------
    task automatic bus(input logic w, r, input logic [7:0] a, dd, input logic [3:0] ev);
        @(posedge mclk_in);
        wr_en_in <= w;
        rd_en_in <= r;
        addr_in <= a;
        wr_data_in <= dd;
        rx_first4_in <= ev[0];
        tx_end_in <= ev[1];
        tick_fast_in <= ev[2];
        tick_slow_in <= ev[3];
        low_freq_oscillator_in <= low_freq_oscillator;
    endtask
    task automatic wr(input logic [7:0] a, dd);
        bus(1'b1, 1'b0, a, dd, 4'h0);
    endtask
    task automatic rd(input logic [7:0] a, e, input string n);
        bus(1'b0, 1'b1, a, 8'h00, 4'h0);
        exp_q.push_back(e);
        name_q.push_back(n);
    endtask
    task automatic tk(input int n, input logic [3:0] ev);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00, ev);
    endtask
    task automatic cmp(input string n, input logic [7:0] e, s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task tally_and_finish;
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe, so look there.
    always @(posedge mclk_in) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) cmp("queue", 8'h00, 8'hFF);
            else cmp(name_q.pop_front(), exp_q.pop_front(), rd_data_out);
        end
        rd_seen <= rd_en_in;
    end

    initial begin
        #1000000;
        mismatches++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    initial begin
        k = $urandom(32'h9ecf2476);
        repeat (4) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rd(8'h0E, 8'h00, "global");
        rd(8'h0F, 8'h00, "ctrl0");
        rd(8'h30, 8'h00, "unmapped");
        wr(8'h0F, 8'hFF);
        rd(8'h0F, 8'hBB, "ctrl0");
        wr(8'h0F, 8'h00);
        run = 8'h00;
        for (k = 0; k < 8; k++) begin
            d = (k == 0) ? 8'hF0 : (k == 1) ? 8'hFF : 8'($urandom);
            m = {d[3:0], 4'h0};
            run = (run & ~m) | (d & m);
            wr(8'h0E, d);
            rd(8'h0E, run, "global");
            #1 cmp("active_port", {4'h0, run[7:4]}, {4'h0, timer_active_out});
        end
        wr(8'h0E, 8'h0F);
        rv = 8'($urandom_range(20, 200));
        wr(8'h11, rv);
        wr(8'h0E, 8'h11);
        tk(3, 4'b0100);
        rd(8'h13, rv - 8'd3, "count_lo");
        rd(8'h12, 8'h00, "count_hi");
        wr(8'h11, rv + 8'd5);
        rd(8'h13, rv - 8'd3, "count_lo");
        wr(8'h0E, 8'h11);
        rd(8'h13, rv + 8'd5, "count_lo");
        wr(8'h0F, 8'h01);
        tk(2, 4'b0100);
        tk(3, 4'b1000);
        rd(8'h13, rv + 8'd2, "count_lo");
        wr(8'h0E, 8'h01);
        for (k = 0; k < 2; k++) begin
            wr(8'h0F, k ? 8'h08 : 8'h00);
            wr(8'h11, 8'h02);
            wr(8'h0E, 8'h11);
            tk(3, 4'b0100);
            tk(3, 4'h0);
            rd(8'h0E, k ? 8'h10 : 8'h00, "global");
            rd(8'h13, k ? 8'h02 : 8'h00, "count_lo");
            rd(8'h23, 8'h01, "irq");
            #1 cmp("irq_port", 8'h01, {4'h0, underflow_irq_flag_out});
            wr(8'h23, 8'h01);
            rd(8'h23, 8'h00, "irq");
            wr(8'h0E, 8'h01);
        end
        for (k = 0; k < 2; k++) begin
            base = k ? 8'h19 : 8'h14;
            wr(base + 8'd2, 8'h01);
            wr(base, 8'h08);
            wr(8'h11, 8'h05);
            wr(8'h0F, k ? 8'h02 : 8'h03);
            wr(8'h0E, k ? 8'h55 : 8'h33);
            tk(4, 4'b0100);
            tk(3, 4'h0);
            rd(8'h13, 8'h03, "cascade");
            wr(8'h0E, 8'h0F);
        end
        wr(8'h11, 8'h01);
        wr(8'h0F, 8'h08);
        wr(8'h16, 8'h05);
        wr(8'h14, 8'h02);
        wr(8'h0E, 8'h33);
        tk(4, 4'b0100);
        tk(3, 4'h0);
        rd(8'h18, 8'h03, "cascade1");
        wr(8'h0E, 8'h0F);
        wr(8'h11, 8'h09);
        for (k = 0; k < 3; k++) begin
            wr(8'h0F, ctl[k]);
            tk(1, 4'b0010);
            rd(8'h0E, e1[k], "auto");
            tk(1, 4'b0001);
            rd(8'h0E, e2[k], "rx");
            wr(8'h0E, 8'h01);
        end
        wr(8'h0F, 8'hA0);
        low_freq_oscillator = 1'b1;
        tk(4, 4'h0);
        rd(8'h0E, 8'h10, "lfo");
        tk(1, 4'b0001);
        rd(8'h0E, 8'h10, "lfo_rx");
        low_freq_oscillator = 1'b0;
        tk(3, 4'h0);
        low_freq_oscillator = 1'b1;
        tk(4, 4'h0);
        rd(8'h0E, 8'h00, "lfo");
        for (k = 0; k < 2; k++) begin
            wr(8'h23, 8'h0F);
            wr(8'h11, 8'h02);
            wr(8'h0F, k ? 8'h30 : 8'h20);
            low_freq_oscillator = 1'b0;
            tk(3, 4'h0);
            low_freq_oscillator = 1'b1;
            tk(3, 4'h0);
            tk(4, 4'b0100);
            rd(8'h23, {7'h00, k[0]}, "lfo_underflow");
            wr(8'h0E, 8'h01);
        end
        tk(4, 4'h0);
        for (k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge mclk_in);
        if (exp_q.size() != 0) mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
